//--- hdl/ppic_gate.sv
// Registered gate that forces a bus to idle while blocked
`timescale 1ns/1ps
`default_nettype none

module ppic_gate #(
  parameter int unsigned WIDTH = 10
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Control
  input wire logic i_pass,
  // Data
  input wire logic [WIDTH-1:0] i_data,
  output logic [WIDTH-1:0] o_data
);

  // Registered bus and its next value
  logic [WIDTH-1:0] data_ff;
  logic [WIDTH-1:0] nxt_data;

  // Idle is all zeros: enables and error flags deasserted
  always_comb begin
    if (i_pass) begin
      nxt_data = i_data;
    end else begin
      nxt_data = '0;
    end
  end

  // Register stage
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      data_ff <= '0;
    end else begin
      data_ff <= nxt_data;
    end
  end

  assign o_data = data_ff;

endmodule : ppic_gate

`default_nettype wire

//--- hdl/ppic_power_isolate.sv
// Power-down and isolate controller of the gigabit coding sublayer
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: Whole GMII runs in one clock domain
// RULE2: MAC may share one clock for both directions
// RULE3: Everything runs on one 125 MHz reference
// RULE4: MAC manages registers over management port
// RULE5: Adaptation module and MAC clock enables advised
// RULE6: Parallel ten-bit variant has no low power
// RULE7: Power-down write enters transceiver low power
// RULE8: Only soft or core reset leaves it
// RULE9: Static power-down bit, released by core reset
// RULE10: Power-up lands in isolate state
// RULE11: Manager writes register 0 to end isolation
// RULE12: Client holds static isolate high at power-on
// RULE13: Isolated: ignore transmit, idle receive outputs
module ppic_power_isolate #(
  parameter bit HAS_MGMT = 1'b1,
  parameter bit SERIAL_XCVR = 1'b1
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_ARST_N,
  // Register port
  input wire logic [ppic_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [ppic_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [ppic_pkg::DATA_W-1:0] O_RDATA,
  // Static configuration vector
  input wire logic I_CFG_PWRDN,
  input wire logic I_CFG_ISOLATE,
  // GMII transmit from the MAC
  input wire logic [ppic_pkg::GMII_D_W-1:0] I_GMII_TXD,
  input wire logic I_GMII_TX_EN,
  input wire logic I_GMII_TX_ER,
  // Transmit towards the coding datapath
  output logic [ppic_pkg::GMII_D_W-1:0] O_PCS_TXD,
  output logic O_PCS_TX_EN,
  output logic O_PCS_TX_ER,
  // Receive from the coding datapath
  input wire logic [ppic_pkg::GMII_D_W-1:0] I_PCS_RXD,
  input wire logic I_PCS_RX_DV,
  input wire logic I_PCS_RX_ER,
  // GMII receive towards the MAC
  output logic [ppic_pkg::GMII_D_W-1:0] O_GMII_RXD,
  output logic O_GMII_RX_DV,
  output logic O_GMII_RX_ER,
  // Power and state outputs
  output logic O_XCVR_PWRDN,
  output logic O_ISOLATED,
  output logic O_SOFT_RESET
);

  // Every flop here sits on I_MCLK, the shared 125 MHz reference
  // clock input; no second clock domain. RULE3
  // No clock enables here, so the MAC's own enables share this tree. RULE5

  // Register index match, used by write and read decode
  function automatic logic reg_hit(
    input logic [ppic_pkg::ADDR_W-1:0] addr,
    input logic [ppic_pkg::ADDR_W-1:0] idx
  );
    reg_hit = (addr == idx);
  endfunction : reg_hit

  // Low power exists only with a serial transceiver
  localparam bit PD_ALLOWED = SERIAL_XCVR; // RULE6

  // Control state
  ppic_pkg::ppic_state_e state_ff; // Operating state
  ppic_pkg::ppic_state_e nxt_state;
  logic isolate_ff; // Isolate request
  logic nxt_isolate;
  logic pwrdn_ff; // Sticky low-power latch
  logic nxt_pwrdn;
  logic soft_rst_ff; // One-cycle datapath reset pulse
  logic nxt_soft_rst;
  logic lowpwr_out_ff; // Registered low-power pin
  logic nxt_lowpwr_out;
  logic isolated_out_ff; // Registered isolated pin
  logic nxt_isolated_out;

  // Register port state
  logic [ppic_pkg::DATA_W-1:0] rdata_ff; // Read data, one cycle late
  logic [ppic_pkg::DATA_W-1:0] nxt_rdata;

  // Decoded write strobes
  logic wr_ctrl; // Write to control register
  logic wr_reset; // Software reset requested
  logic wr_pwrdn; // Power-down requested by write

  // Gate controls and bundles
  logic pass; // Traffic allowed
  logic [ppic_pkg::GMII_W-1:0] tx_in; // Bundled transmit inputs
  logic [ppic_pkg::GMII_W-1:0] tx_out; // Gated transmit
  logic [ppic_pkg::GMII_W-1:0] rx_in; // Bundled receive inputs
  logic [ppic_pkg::GMII_W-1:0] rx_out; // Gated receive

  // Write decode, only live with the management interface
  always_comb begin
    wr_ctrl = HAS_MGMT && I_WR && reg_hit(I_ADDR, ppic_pkg::REG_CTRL); // RULE4
    wr_reset = wr_ctrl && I_WDATA[ppic_pkg::CTRL_RESET_BIT];
    wr_pwrdn = wr_ctrl && I_WDATA[ppic_pkg::CTRL_PWRDN_BIT];
  end

  // Isolate request next value
  always_comb begin
    nxt_isolate = isolate_ff;
    if (HAS_MGMT) begin
      // Soft reset returns to the power-up isolate default
      if (wr_reset) begin
        nxt_isolate = ppic_pkg::RST_ISOLATE; // RULE10
      end else if (wr_ctrl) begin
        // Manager clears or sets isolation here
        nxt_isolate = I_WDATA[ppic_pkg::CTRL_ISOLATE_BIT];
      end
    end else begin
      // Static vector steers isolation directly
      nxt_isolate = I_CFG_ISOLATE;
    end
  end

  // Sticky low-power latch next value
  always_comb begin
    nxt_pwrdn = pwrdn_ff;
    if (!PD_ALLOWED) begin
      // Parallel ten-bit variant: never low power
      nxt_pwrdn = 1'b0; // RULE6
    end else if (HAS_MGMT) begin
      if (wr_reset) begin
        // Software reset is the register-side way out
        nxt_pwrdn = ppic_pkg::RST_PWRDN; // RULE8
      end else if (wr_pwrdn) begin
        // Writing the power-down bit enters low power
        nxt_pwrdn = 1'b1; // RULE7
      end
      // Clearing the bit by a write has no effect
    end else if (I_CFG_PWRDN) begin
      // Static bit enters; only the core reset port clears
      nxt_pwrdn = 1'b1; // RULE9
    end
  end

  // Software reset pulse next value
  always_comb begin
    nxt_soft_rst = wr_reset; // RULE8
  end

  // Pin flags decoded from the next state, so the pins come from flops
  always_comb begin
    nxt_lowpwr_out = (nxt_state == ppic_pkg::ST_LOWPWR); // RULE7 RULE9
    nxt_isolated_out = (nxt_state != ppic_pkg::ST_ACTIVE); // RULE13
  end

  // Operating state next value
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      // Isolated: wait for isolation to clear
      ppic_pkg::ST_ISOLATE: begin
        if (nxt_pwrdn) begin
          nxt_state = ppic_pkg::ST_LOWPWR;
        end else if (!nxt_isolate) begin
          nxt_state = ppic_pkg::ST_ACTIVE;
        end
      end
      // Active: traffic flows
      ppic_pkg::ST_ACTIVE: begin
        if (nxt_pwrdn) begin
          nxt_state = ppic_pkg::ST_LOWPWR;
        end else if (nxt_isolate) begin
          nxt_state = ppic_pkg::ST_ISOLATE;
        end
      end
      // Low power: held until a reset clears the latch
      ppic_pkg::ST_LOWPWR: begin
        if (!nxt_pwrdn) begin
          nxt_state = ppic_pkg::ST_ISOLATE; // RULE8
        end
      end
      // Unused encoding recovers to isolate
      default: begin
        nxt_state = ppic_pkg::ST_ISOLATE;
      end
    endcase
  end

  // Read data next value, zero for unmapped or idle
  always_comb begin
    nxt_rdata = ppic_pkg::RST_RDATA;
    if (I_RD && reg_hit(I_ADDR, ppic_pkg::REG_CTRL)) begin
      // Reset bit self clears and reads zero
      nxt_rdata[ppic_pkg::CTRL_PWRDN_BIT] = pwrdn_ff;
      nxt_rdata[ppic_pkg::CTRL_ISOLATE_BIT] = isolate_ff;
    end else if (I_RD && reg_hit(I_ADDR, ppic_pkg::REG_STAT)) begin
      // Live state and build options
      nxt_rdata[ppic_pkg::STAT_LOWPWR_BIT] = (state_ff == ppic_pkg::ST_LOWPWR);
      nxt_rdata[ppic_pkg::STAT_ISOLATED_BIT] = (state_ff != ppic_pkg::ST_ACTIVE);
      nxt_rdata[ppic_pkg::STAT_MGMT_BIT] = HAS_MGMT;
      nxt_rdata[ppic_pkg::STAT_SERIAL_BIT] = SERIAL_XCVR;
    end
  end

  // Control state registers; power-up lands isolated
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_ff <= ppic_pkg::ST_ISOLATE; // RULE10
      isolate_ff <= ppic_pkg::RST_ISOLATE; // RULE10
      pwrdn_ff <= ppic_pkg::RST_PWRDN; // RULE8 RULE9
      soft_rst_ff <= 1'b0;
      lowpwr_out_ff <= ppic_pkg::RST_PWRDN;
      isolated_out_ff <= ppic_pkg::RST_ISOLATE; // RULE10
    end else begin
      state_ff <= nxt_state;
      isolate_ff <= nxt_isolate;
      pwrdn_ff <= nxt_pwrdn;
      soft_rst_ff <= nxt_soft_rst;
      lowpwr_out_ff <= nxt_lowpwr_out;
      isolated_out_ff <= nxt_isolated_out;
    end
  end

  // Register port read data
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdata_ff <= ppic_pkg::RST_RDATA;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Traffic passes only in the active state
  always_comb begin
    pass = (state_ff == ppic_pkg::ST_ACTIVE); // RULE13
  end

  // Bundle the GMII groups for the gates
  always_comb begin
    tx_in = {I_GMII_TX_ER, I_GMII_TX_EN, I_GMII_TXD};
    rx_in = {I_PCS_RX_ER, I_PCS_RX_DV, I_PCS_RXD};
  end

  // Transmit gate: MAC input ignored while isolated
  ppic_gate #(
    .WIDTH(ppic_pkg::GMII_W)
  ) u_tx_gate (
    .i_clk(I_MCLK),
    .i_arst_n(I_ARST_N),
    .i_pass(pass),
    .i_data(tx_in),
    .o_data(tx_out)
  ); // RULE13 RULE1

  // Receive gate: outputs idle while isolated
  ppic_gate #(
    .WIDTH(ppic_pkg::GMII_W)
  ) u_rx_gate (
    .i_clk(I_MCLK),
    .i_arst_n(I_ARST_N),
    .i_pass(pass),
    .i_data(rx_in),
    .o_data(rx_out)
  ); // RULE13 RULE1

  // Unbundle gated transmit
  assign O_PCS_TXD = tx_out[ppic_pkg::GMII_D_W-1:0];
  assign O_PCS_TX_EN = tx_out[ppic_pkg::GMII_D_W];
  assign O_PCS_TX_ER = tx_out[ppic_pkg::GMII_D_W+1];

  // Unbundle gated receive
  assign O_GMII_RXD = rx_out[ppic_pkg::GMII_D_W-1:0];
  assign O_GMII_RX_DV = rx_out[ppic_pkg::GMII_D_W];
  assign O_GMII_RX_ER = rx_out[ppic_pkg::GMII_D_W+1];

  // State and register outputs, all from flops
  assign O_RDATA = rdata_ff;
  assign O_XCVR_PWRDN = lowpwr_out_ff; // RULE7 RULE9
  assign O_ISOLATED = isolated_out_ff;
  assign O_SOFT_RESET = soft_rst_ff;

endmodule : ppic_power_isolate

`default_nettype wire

//--- pkg/ppic_pkg.sv
// Package: constants for the power-down and isolate controller
package ppic_pkg;

  // Register bus widths
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  // Register indices on the management port
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;

  // Control register field positions
  localparam int unsigned CTRL_RESET_BIT = 15;
  localparam int unsigned CTRL_PWRDN_BIT = 11;
  localparam int unsigned CTRL_ISOLATE_BIT = 10;

  // Status register field positions
  localparam int unsigned STAT_LOWPWR_BIT = 0;
  localparam int unsigned STAT_ISOLATED_BIT = 1;
  localparam int unsigned STAT_MGMT_BIT = 2;
  localparam int unsigned STAT_SERIAL_BIT = 3;

  // Reset values of the control state
  localparam logic RST_ISOLATE = 1'b1;
  localparam logic RST_PWRDN = 1'b0;
  localparam logic [15:0] RST_RDATA = 16'h0000;

  // GMII widths
  localparam int unsigned GMII_D_W = 8;
  localparam int unsigned GMII_W = 10;

  // Reference clock of the integrated design, in MHz
  localparam int unsigned REF_CLK_MHZ = 125;

  // Operating state, Gray coded along isolate, active, low power
  typedef enum logic [1:0] {
    ST_ISOLATE = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_LOWPWR = 2'b11
  } ppic_state_e;

endpackage : ppic_pkg

//--- verification/ppic_mac_model.sv
// Far-side stream model: MAC transmit and datapath receive traffic
`timescale 1ns/1ps
`default_nettype none
module ppic_mac_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Streams towards the device
  output logic [7:0] o_txd,
  output logic o_tx_en,
  output logic o_tx_er,
  output logic [7:0] o_rxd,
  output logic o_rx_dv,
  output logic o_rx_er
);
  logic [7:0] cnt_ff; // Pattern counter
  logic [7:0] nxt_cnt; // Next pattern
  // Pattern changes every cycle so stale data never matches
  always_comb begin
    nxt_cnt = cnt_ff + 8'h03;
  end
  // Both directions advance on the one shared clock
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_ff <= 8'h5a;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  // Transmit and receive differ so a swap shows
  assign o_txd = cnt_ff;
  assign o_tx_en = cnt_ff[0];
  assign o_tx_er = cnt_ff[2];
  assign o_rxd = ~cnt_ff;
  assign o_rx_dv = cnt_ff[1];
  assign o_rx_er = cnt_ff[3];
endmodule : ppic_mac_model
`default_nettype wire

//--- verification/ppic_power_isolate_bench.sv
// Self-checking bench for the power-down and isolate controller
`timescale 1ns/1ps
`default_nettype none
module ppic_power_isolate_bench;
  typedef struct {logic w; logic r; logic [4:0] a; logic [15:0] d; logic [15:0] e;} ppic_row_s;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [7:0] txd, rxd, ptxd, grxd;
  logic tx_en, tx_er, rx_dv, rx_er, ptx_en, ptx_er, grx_dv, grx_er, pwrdn, iso, srst, seen;
  logic cfg_pwrdn = 1'b0;
  logic cfg_iso = 1'b1;
  logic pwrdn_st, iso_st, pwrdn_par, iso_par;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  ppic_row_s rows [9] = '{'{0, 1, 5'h01, 16'h0000, 16'h000e}, '{0, 1, 5'h00, 16'h0000, 16'h0400},
    '{0, 1, 5'h07, 16'h0000, 16'h0000}, '{1, 0, 5'h05, 16'hffff, 16'h0000},
    '{0, 1, 5'h00, 16'h0000, 16'h0400}, '{1, 0, 5'h00, 16'h0000, 16'h0000},
    '{1, 0, 5'h01, 16'h000f, 16'h0000}, '{0, 1, 5'h01, 16'h0000, 16'h000c},
    '{0, 1, 5'h00, 16'h0000, 16'h0000}};
  // Clock at 100 MHz
  always #5 clk = ~clk;
  ppic_mac_model u_mac (.i_clk(clk), .i_arst_n(arst_n), .o_txd(txd), .o_tx_en(tx_en),
    .o_tx_er(tx_er), .o_rxd(rxd), .o_rx_dv(rx_dv), .o_rx_er(rx_er));
  ppic_power_isolate dut (.I_MCLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_CFG_PWRDN(1'b0), .I_CFG_ISOLATE(1'b0),
    .I_GMII_TXD(txd), .I_GMII_TX_EN(tx_en), .I_GMII_TX_ER(tx_er), .O_PCS_TXD(ptxd),
    .O_PCS_TX_EN(ptx_en), .O_PCS_TX_ER(ptx_er), .I_PCS_RXD(rxd), .I_PCS_RX_DV(rx_dv),
    .I_PCS_RX_ER(rx_er), .O_GMII_RXD(grxd), .O_GMII_RX_DV(grx_dv), .O_GMII_RX_ER(grx_er),
    .O_XCVR_PWRDN(pwrdn), .O_ISOLATED(iso), .O_SOFT_RESET(srst));
  // Static vector build: shared bus writes must be ignored
  ppic_power_isolate #(.HAS_MGMT(1'b0)) dut_st (.I_MCLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(), .I_CFG_PWRDN(cfg_pwrdn),
    .I_CFG_ISOLATE(cfg_iso), .I_GMII_TXD(txd), .I_GMII_TX_EN(tx_en), .I_GMII_TX_ER(tx_er),
    .O_PCS_TXD(), .O_PCS_TX_EN(), .O_PCS_TX_ER(), .I_PCS_RXD(rxd), .I_PCS_RX_DV(rx_dv),
    .I_PCS_RX_ER(rx_er), .O_GMII_RXD(), .O_GMII_RX_DV(), .O_GMII_RX_ER(),
    .O_XCVR_PWRDN(pwrdn_st), .O_ISOLATED(iso_st), .O_SOFT_RESET());
  // Parallel ten-bit build: power-down writes must not take effect
  ppic_power_isolate #(.SERIAL_XCVR(1'b0)) dut_par (.I_MCLK(clk), .I_ARST_N(arst_n),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(), .I_CFG_PWRDN(1'b0),
    .I_CFG_ISOLATE(1'b0), .I_GMII_TXD(txd), .I_GMII_TX_EN(tx_en), .I_GMII_TX_ER(tx_er),
    .O_PCS_TXD(), .O_PCS_TX_EN(), .O_PCS_TX_ER(), .I_PCS_RXD(rxd), .I_PCS_RX_DV(rx_dv),
    .I_PCS_RX_ER(rx_er), .O_GMII_RXD(), .O_GMII_RX_DV(), .O_GMII_RX_ER(),
    .O_XCVR_PWRDN(pwrdn_par), .O_ISOLATED(iso_par), .O_SOFT_RESET());
  // Counted comparison
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (!ok) begin
      errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk
  // One bus cycle, read data checked in the slot after the strobe
  task automatic bus(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d,
                     input logic [15:0] e);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    if (r) chk(rdata === e, "read data mismatch");
  endtask : bus
  // Gated outputs follow last cycle's inputs, or stay idle
  task automatic watch(input logic pass, input logic lp);
    logic [9:0] t, v;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      t = {tx_en, tx_er, txd};
      v = {rx_dv, rx_er, rxd};
      #1;
      chk({ptx_en, ptx_er, ptxd} === (pass ? t : 10'h000), "transmit gate wrong");
      chk({grx_dv, grx_er, grxd} === (pass ? v : 10'h000), "receive gate wrong");
      chk({pwrdn, iso} === {lp, !pass}, "power or isolate state wrong");
    end
  endtask : watch
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    watch(1'b0, 1'b0);
    foreach (rows[i]) bus(rows[i].w, rows[i].r, rows[i].a, rows[i].d, rows[i].e);
    watch(1'b1, 1'b0);
    $display("register rows and traffic done");
    bus(1'b1, 1'b0, 5'h00, 16'h0800, 16'h0000);
    bus(1'b1, 1'b0, 5'h00, 16'h0000, 16'h0000);
    watch(1'b0, 1'b1);
    chk({pwrdn_par, iso_par} === 2'b00, "parallel variant entered low power");
    bus(1'b0, 1'b1, 5'h01, 16'h0000, 16'h000f);
    bus(1'b1, 1'b0, 5'h00, 16'h8800, 16'h0000);
    seen = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (srst === 1'b1) seen = 1'b1;
      @(posedge clk);
      #1;
    end
    chk(seen === 1'b1, "no soft reset pulse");
    bus(1'b0, 1'b1, 5'h00, 16'h0000, 16'h0400);
    watch(1'b0, 1'b0);
    $display("power-down and soft reset done");
    bus(1'b1, 1'b0, 5'h00, 16'h0800, 16'h0000);
    watch(1'b0, 1'b1);
    @(posedge clk);
    cfg_iso <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({pwrdn_st, iso_st} === 2'b00, "static isolate not cleared");
    @(posedge clk);
    cfg_pwrdn <= 1'b1;
    @(posedge clk);
    cfg_pwrdn <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({pwrdn_st, iso_st} === 2'b11, "static power-down not held");
    $display("static vector done");
    @(posedge clk);
    arst_n <= 1'b0;
    cfg_iso <= 1'b1;
    @(posedge clk);
    #1;
    chk({pwrdn, iso, ptx_en, grx_dv} === 4'h4, "core reset state wrong");
    chk({pwrdn_st, iso_st} === 2'b01, "static core reset state wrong");
    @(posedge clk);
    arst_n <= 1'b1;
    watch(1'b0, 1'b0);
    chk({pwrdn_st, iso_st} === 2'b01, "static build not isolated at start");
    $display("core reset done");
    finish_test();
  end
endmodule : ppic_power_isolate_bench
`default_nettype wire

//--- verification/ppic_power_isolate_chk.sv
// Port checker for the power-down and isolate controller
`timescale 1ns/1ps
`default_nettype none
module ppic_power_isolate_chk #(
  parameter bit HAS_MGMT = 1'b1,
  parameter bit SERIAL_XCVR = 1'b1
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_ARST_N,
  // Static configuration
  input wire logic I_CFG_PWRDN,
  // Register port
  input wire logic [ppic_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [ppic_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [ppic_pkg::DATA_W-1:0] O_RDATA,
  // Gated streams
  input wire logic [ppic_pkg::GMII_D_W-1:0] I_GMII_TXD,
  input wire logic [ppic_pkg::GMII_D_W-1:0] I_PCS_RXD,
  input wire logic [ppic_pkg::GMII_D_W-1:0] O_PCS_TXD,
  input wire logic O_PCS_TX_EN,
  input wire logic [ppic_pkg::GMII_D_W-1:0] O_GMII_RXD,
  input wire logic O_GMII_RX_DV,
  // Power and state
  input wire logic O_XCVR_PWRDN,
  input wire logic O_ISOLATED,
  input wire logic O_SOFT_RESET
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_ARST_N);
  // Control register write and soft reset decode
  logic ctl_wr;
  logic soft_wr;
  assign ctl_wr = HAS_MGMT && I_WR && (I_ADDR == ppic_pkg::REG_CTRL);
  assign soft_wr = ctl_wr && I_WDATA[ppic_pkg::CTRL_RESET_BIT];
  a_rdata_idle: assert property (!I_RD |=> O_RDATA == 16'h0000)
    else $error("read data not zero outside read slot");
  a_tx_pass: assert property (!O_ISOLATED |=> O_PCS_TXD == $past(I_GMII_TXD))
    else $error("transmit not passed while active");
  a_rx_pass: assert property (!O_ISOLATED |=> O_GMII_RXD == $past(I_PCS_RXD))
    else $error("receive not passed while active");
  a_tx_blocked: assert property (O_ISOLATED |=> !O_PCS_TX_EN && O_PCS_TXD == 8'h00)
    else $error("transmit leaks while isolated");
  a_rx_idle: assert property (O_ISOLATED |=> !O_GMII_RX_DV && O_GMII_RXD == 8'h00)
    else $error("receive not idle while isolated");
  a_lowpwr_isolates: assert property (O_XCVR_PWRDN |-> O_ISOLATED)
    else $error("low power without isolation");
  a_pwrdn_entry: assert property (SERIAL_XCVR && ctl_wr && I_WDATA[11] && !soft_wr
    |-> ##[1:2] O_XCVR_PWRDN)
    else $error("power-down write ignored");
  a_par_no_lowpwr: assert property (!SERIAL_XCVR && ctl_wr && I_WDATA[11] |=> !O_XCVR_PWRDN)
    else $error("parallel variant entered low power");
  a_cfg_pwrdn: assert property (!HAS_MGMT && SERIAL_XCVR && I_CFG_PWRDN |=> O_XCVR_PWRDN)
    else $error("static power-down bit ignored");
  a_cfg_hold: assert property (!HAS_MGMT && O_XCVR_PWRDN |=> O_XCVR_PWRDN)
    else $error("static low power left without core reset");
  a_pwrdn_hold: assert property (O_XCVR_PWRDN && !soft_wr && !$past(soft_wr) |=> O_XCVR_PWRDN)
    else $error("low power left without reset");
  a_soft_cause: assert property (soft_wr |-> ##[1:2] O_SOFT_RESET)
    else $error("soft reset write gave no pulse");
  a_soft_pulse: assert property (O_SOFT_RESET && !soft_wr |=> !O_SOFT_RESET)
    else $error("soft reset pulse too long");
  // Main scenarios reached
  c_lowpwr: cover property (O_XCVR_PWRDN);
  c_soft: cover property (O_SOFT_RESET);
  c_traffic: cover property (!O_ISOLATED && O_PCS_TX_EN);
  c_static_lowpwr: cover property (!HAS_MGMT && O_XCVR_PWRDN);
endmodule : ppic_power_isolate_chk
bind ppic_power_isolate ppic_power_isolate_chk #(.HAS_MGMT(HAS_MGMT), .SERIAL_XCVR(SERIAL_XCVR))
  u_chk (.I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_CFG_PWRDN(I_CFG_PWRDN),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_GMII_TXD(I_GMII_TXD), .I_PCS_RXD(I_PCS_RXD), .O_PCS_TXD(O_PCS_TXD),
  .O_PCS_TX_EN(O_PCS_TX_EN), .O_GMII_RXD(O_GMII_RXD), .O_GMII_RX_DV(O_GMII_RX_DV),
  .O_XCVR_PWRDN(O_XCVR_PWRDN), .O_ISOLATED(O_ISOLATED), .O_SOFT_RESET(O_SOFT_RESET));
`default_nettype wire
